// >>> pkg/sirq_pkg.sv
// sirq_pkg: shared types and constants for the serial interrupt peripheral.
// assumes the link clock is sampled by the system clock, far faster than the link.
package sirq_pkg;

    // frame geometry of one serial interrupt cycle
    localparam int unsigned FRAME_CNT = 32; // total frames a host may run
    localparam int unsigned OWN_FRAMES = 21; // frames this peripheral reports
    localparam logic [5:0] FRAME_LAST = 6'h20; // saturation value of the frame counter
    localparam logic [5:0] FRAME_PRE = 6'h3f; // wraps to frame 0 on the first step
    localparam logic [5:0] FRAME_OWN_END = 6'h15; // first frame index not owned here

    // phases inside one frame
    localparam logic [1:0] PH_SAMPLE = 2'h0;
    localparam logic [1:0] PH_RECOVER = 2'h1;
    localparam logic [1:0] PH_TURN = 2'h2;

    // pulse widths, in link clocks
    localparam logic [3:0] START_MIN_CLKS = 4'h4; // least start pulse width
    localparam logic [3:0] START_MAX_CLKS = 4'h8; // widest start pulse width
    localparam logic [3:0] STOP_QUIET_CLKS = 4'h2; // stop width choosing quiet mode
    localparam logic [3:0] STOP_CONT_CLKS = 4'h3; // stop width choosing continuous mode
    localparam logic [3:0] LOW_CNT_MAX = 4'hf; // saturation of the low-width counter

    // synchroniser depth for pins
    localparam int unsigned SYNC_STAGES = 2;

    // cycle sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, // line idle, waiting for a start
        ST_QSTART = 3'b001, // driving the one-clock quiet start
        ST_START = 3'b010, // start pulse low, measuring it
        ST_FRAMES = 3'b011, // walking the data frames
        ST_STOP = 3'b100 // stop pulse low, measuring it
    } sirq_state_e;

    // interrupt sources reported on the line
    typedef struct packed {
        logic [3:0] pci_int; // inta..intd, bit 0 is inta
        logic iochck; // channel check
        logic smi; // system management interrupt
        logic [15:0] isa_irq; // legacy interrupts 0..15, bit 2 not reported
    } sirq_src_s;

    // state of the open-drain pin as driven by this block
    typedef struct packed {
        logic oe; // high while this block drives the pin
        logic o; // level driven while oe is high
    } sirq_pin_s;

endpackage

// >>> verif/sirq_host_model.sv
// sirq_host_model: host end of the shared line, runs whole cycles on request.
// assumes the bench resolves the open-drain wire; host only ever pulls low.
`timescale 1ns/1ps
module sirq_host_model (
    output logic link_clk,
    output logic host_low,
    input wire logic line
);
    // free-running link clock, offset from clk_sys edges to avoid races
    initial begin
        host_low = 1'b0;
        link_clk = 1'b0;
        // rising edges at 44 + 80n, so host changes two ns later land between clk_sys edges
        #4;
        forever #40 link_clk = ~link_clk;
    end
    // hold a pull level for n link periods, changing just after an edge
    task automatic drive(input int n, input logic low);
        host_low = low;
        repeat (n) @(posedge link_clk);
        #2;
    endtask
    // one cycle; ext above zero waits for the peripheral's quiet start
    task automatic cycle(input int start_w, input int ext, input int stop_w, input int idle,
                         output logic [20:0] got, output logic ok);
        int k;
        got = 21'h00_0000;
        ok = 1'b1;
        if (ext > 0) begin
            k = 0;
            do begin
                @(posedge link_clk);
                k++;
            end while (line !== 1'b0 && k < 200);
            #2;
            ok = (k < 200);
            drive(ext, 1'b1);
        end else begin
            @(posedge link_clk);
            #2;
            drive(start_w, 1'b1);
        end
        // reference period: host ends its pulse by releasing to the pull-up
        drive(1, 1'b0);
        for (k = 1; k <= 64; k++) begin
            @(posedge link_clk);
            if (k >= 2 && (k - 2) % 3 == 0) got[(k - 2) / 3] = ~line;
        end
        #2;
        drive(stop_w, 1'b1);
        drive(1 + idle, 1'b0);
    endtask
endmodule // sirq_host_model

// >>> verif/sirq_periph_sva.sv
// sirq_periph_sva: timing checks on the peripheral's pin drive and mode flags.
// assumes an 80 ns link clock, so one link period is eight clk_sys cycles.
`timescale 1ns/1ps
module sirq_periph_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link pins
    input wire logic link_clk,
    input wire logic shared_irq_line_i,
    input wire logic shared_irq_line_o,
    input wire logic shared_irq_line_oe,
    // sources and status
    input wire sirq_pkg::sirq_src_s irq_src,
    input wire logic quiet_mode,
    input wire logic cycle_active
);
    import sirq_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // decoded drive kinds of the open-drain pin
    logic drv_low;
    logic drv_high;
    assign drv_low = shared_irq_line_oe & ~shared_irq_line_o;
    assign drv_high = shared_irq_line_oe & shared_irq_line_o;
    // one drive lasts exactly one link period, then ends
    sequence s_low_period;
        drv_low [*8] ##1 !drv_low;
    endsequence
    sequence s_high_period;
        drv_high [*8] ##1 !drv_high;
    endsequence
    idle_silent_a: assert property (!quiet_mode && !cycle_active |-> !shared_irq_line_oe)
        else $error("pin driven while idle in continuous mode");
    reset_idle_a: assert property ($rose(reset_n) |-> !quiet_mode && !cycle_active)
        else $error("not idle continuous after reset");
    low_one_period_a: assert property ($rose(drv_low) |-> s_low_period)
        else $error("low drive not one link period");
    high_one_period_a: assert property ($rose(drv_high) |-> s_high_period)
        else $error("recovery drive not one link period");
    high_after_low_a: assert property ($rose(drv_high) |-> $past(drv_low))
        else $error("high drive without preceding low");
    turn_release_a: assert property ($fell(drv_high) |-> !shared_irq_line_oe [*8])
        else $error("pin driven in turn-around");
    cont_needs_cycle_a: assert property (drv_low && !quiet_mode |-> $past(cycle_active, 8))
        else $error("continuous mode drive outside a cycle");
    mode_at_end_a: assert property ($changed(quiet_mode) |-> !cycle_active)
        else $error("mode changed inside a cycle");
endmodule // sirq_periph_sva

bind sirq_periph sirq_periph_sva chk (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
    .shared_irq_line_i(shared_irq_line_i), .shared_irq_line_o(shared_irq_line_o),
    .shared_irq_line_oe(shared_irq_line_oe), .irq_src(irq_src), .quiet_mode(quiet_mode),
    .cycle_active(cycle_active));

// >>> verif/tb.sv
// tb: self-checking bench for the serial interrupt peripheral.
// assumes the host model owns the link clock; the wire is pulled up when nobody pulls low.
`timescale 1ns/1ps
module tb;
    import sirq_pkg::*;
    logic clk_sys;
    logic reset_n;
    sirq_src_s irq_src;
    logic link_clk;
    logic host_low;
    logic line_o;
    logic line_oe;
    logic quiet_mode;
    logic cycle_active;
    int errors;
    int compares;
    int cycles;
    // open-drain wire: any pull low wins, recovery drive and pull-up read high
    wire line = !(host_low || (line_oe && !line_o));
    sirq_periph DUT (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
        .shared_irq_line_i(line), .shared_irq_line_o(line_o), .shared_irq_line_oe(line_oe),
        .irq_src(irq_src), .quiet_mode(quiet_mode), .cycle_active(cycle_active));
    sirq_host_model host (.link_clk(link_clk), .host_low(host_low), .line(line));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard: the run needs about 3000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            $display("unexpected at %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    // frame order: irq0, irq1, smi, irq3..15, iochck, inta..intd
    function automatic logic [20:0] exp_vec(input sirq_src_s s);
        return {s.pci_int, s.iochck, s.isa_irq[15:3], s.smi, s.isa_irq[1:0]};
    endfunction
    task automatic chk_vec(input logic [20:0] got, input logic [20:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: frames %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    // shared body: set sources, let the host run a cycle, judge frames and mode
    task automatic run_cycle(input sirq_src_s src, input int start_w, input int ext,
                             input int stop_w, input int idle, input logic quiet);
        logic [20:0] got;
        logic ok;
        @(posedge clk_sys);
        #1 irq_src = src;
        host.cycle(start_w, ext, stop_w, idle, got, ok);
        chk_bit(ok, 1'b1);
        chk_vec(got, exp_vec(src));
        // the mode flips about three clk_sys cycles after the post-stop link edge
        repeat (4) @(posedge clk_sys);
        #1 chk_bit(quiet_mode, quiet);
    endtask
    // changed sources must not open a cycle in continuous mode
    task automatic t_no_start(input sirq_src_s src);
        logic low_seen;
        low_seen = 1'b0;
        @(posedge clk_sys);
        #1 irq_src = src;
        repeat (30) begin
            @(posedge link_clk);
            if (line !== 1'b1) low_seen = 1'b1;
        end
        chk_bit(low_seen, 1'b0);
        chk_bit(cycle_active, 1'b0);
        $display("test no_start done");
    endtask
    // first cycle after reset, shortest start, three-clock stop
    task automatic t_cont_short();
        run_cycle(22'h15_5555, 4, 0, 3, 2, 1'b0);
        $display("test cont_short done");
    endtask
    // longest start, two-clock stop, host returns right after turn-around
    task automatic t_cont_long();
        run_cycle(22'h2a_aaaa, 8, 0, 2, 0, 1'b1);
        $display("test cont_long done");
    endtask
    // peripheral opens the cycle, host extends by three
    task automatic t_quiet_short();
        run_cycle(22'h00_0001, 0, 3, 2, 3, 1'b1);
        $display("test quiet_short done");
    endtask
    // peripheral opens, host extends by seven, returns to continuous
    task automatic t_quiet_long();
        run_cycle(22'h20_0008, 0, 7, 3, 2, 1'b0);
        $display("test quiet_long done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        irq_src = 22'h00_0000;
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        t_no_start(22'h3f_ffff);
        t_cont_short();
        t_cont_long();
        t_quiet_short();
        t_quiet_long();
        t_no_start(22'h0c_0000);
        tally_and_finish();
    end
endmodule // tb

// >>> verilog/sirq_periph.sv
// sirq_periph: peripheral end of the shared serial interrupt line.
// assumes the link clock and the line arrive from pins; the sources come from logic on clk_sys.
`timescale 1ns/1ps

// What this block does
// - start pulse lasts four to eight clocks; the block counts the width but accepts any
// - quiet start: drive low one clock, release
// - reset enters continuous mode, waits for host
// - frame counting referenced to start rising edge
// - frame is sample, recovery, turn-around clocks
// - sample phase: pull low if source active
// - recovery drives high, turn-around released
// - first sample two clocks after reference, then three
// - fixed mapping of sources onto frames
// - stop width selects quiet or continuous mode
// - idle states or immediate start after stop accepted
// - open-drain line: pull low, drive high in recovery, or release
// - all timing counted in link clock periods
module sirq_periph (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link pins
    input wire logic link_clk,
    input wire logic shared_irq_line_i,
    output logic shared_irq_line_o,
    output logic shared_irq_line_oe,
    // interrupt sources, same clock domain
    input wire sirq_pkg::sirq_src_s irq_src,
    // status
    output logic quiet_mode,
    output logic cycle_active
);
    import sirq_pkg::*;

    // synchronised pins
    logic [1:0] pin_sync; // bit 1 link clock, bit 0 line level
    logic lclk_s; // synchronised link clock
    logic line_s; // synchronised line level
    logic lclk_last_q; // previous synchronised link clock
    logic lclk_rise; // one-cycle pulse on a link clock rising edge
    logic lclk_fall; // one-cycle pulse on a link clock falling edge
    logic line_smp_q; // line level caught mid-period

    // sequencer
    sirq_state_e state_q; // current state
    logic [3:0] low_cnt_q; // length of the current low pulse in link clocks
    logic [1:0] phase_q; // phase of the current link period
    logic [5:0] frame_q; // frame index of the current period, zero based
    logic drove_low_q; // this block pulled the line low in the sample phase
    logic quiet_q; // mode chosen by the last stop pulse
    sirq_pin_s pin_q; // registered pin drive

    // source mapping and change tracking
    logic [FRAME_CNT-1:0] frame_vec; // bit n is the value for frame n
    logic [FRAME_CNT-1:0] last_vec_q; // values last sent on the line
    logic change_pend; // a reported value differs from what was last sent

    // both link pins pass two flops before anything reads them
    sirq_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({link_clk, shared_irq_line_i}),
        .sync_out(pin_sync)
    );

    assign lclk_s = pin_sync[1];
    assign line_s = pin_sync[0];
    assign lclk_rise = lclk_s & ~lclk_last_q;
    assign lclk_fall = ~lclk_s & lclk_last_q;

    // fixed placement of sources on frames; unassigned frames stay released
    always_comb begin
        frame_vec = '0;
        frame_vec[0] = irq_src.isa_irq[0];
        frame_vec[1] = irq_src.isa_irq[1];
        frame_vec[2] = irq_src.smi;
        frame_vec[15:3] = irq_src.isa_irq[15:3];
        frame_vec[16] = irq_src.iochck;
        frame_vec[20:17] = irq_src.pci_int;
    end

    // a quiet start is only worth making when something has moved
    assign change_pend = (frame_vec != last_vec_q);

    // link clock edge finder; the line is caught mid-period so it has settled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lclk_last_q <= 1'b0;
            line_smp_q <= 1'b1;
        end else begin
            lclk_last_q <= lclk_s;
            if (lclk_fall) begin
                line_smp_q <= line_s;
            end
        end
    end

    // cycle sequencer; each step sees the line of the period just ended
    // and sets the drive for the period just begun
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            low_cnt_q <= '0;
            phase_q <= PH_TURN;
            frame_q <= FRAME_PRE;
            drove_low_q <= 1'b0;
            quiet_q <= 1'b0;
            pin_q <= '{oe: 1'b0, o: 1'b0};
            last_vec_q <= '0;
        end else if (lclk_rise) begin
            // default: release the line; only the cases below drive it
            pin_q <= '{oe: 1'b0, o: 1'b0};
            case (state_q)
                ST_IDLE: begin
                    // a low line is a start from the host, or a peer's quiet start
                    if (!line_smp_q) begin
                        state_q <= ST_START;
                        low_cnt_q <= 4'h1;
                    end else if (quiet_q && change_pend) begin
                        // continuous mode never gets here: only the host starts
                        state_q <= ST_QSTART;
                        pin_q <= '{oe: 1'b1, o: 1'b0};
                    end
                end
                ST_QSTART: begin
                    // one clock of own drive done; the host carries the pulse on
                    state_q <= ST_START;
                    low_cnt_q <= 4'h1;
                end
                ST_START: begin
                    if (!line_smp_q) begin
                        // width is measured only for visibility; any 4..8 is accepted
                        if (low_cnt_q != LOW_CNT_MAX) begin
                            low_cnt_q <= low_cnt_q + 4'h1;
                        end
                    end else begin
                        // the period just ended was the first high one: the
                        // reference; the new period is one past it, a turn-around
                        state_q <= ST_FRAMES;
                        phase_q <= PH_TURN;
                        frame_q <= FRAME_PRE;
                        drove_low_q <= 1'b0;
                    end
                end
                ST_FRAMES: begin
                    if (phase_q == PH_RECOVER && !line_smp_q && !drove_low_q) begin
                        // low through sample and recovery without us: the stop
                        state_q <= ST_STOP;
                        low_cnt_q <= STOP_QUIET_CLKS;
                        drove_low_q <= 1'b0;
                    end else begin
                        case (phase_q)
                            PH_TURN: begin
                                // next frame begins with its sample phase
                                phase_q <= PH_SAMPLE;
                                if (frame_q != FRAME_LAST) begin
                                    frame_q <= frame_q + 6'h01;
                                end
                                if (frame_q == FRAME_PRE ||
                                        (frame_q + 6'h01) < FRAME_OWN_END) begin
                                    if (frame_vec[frame_q[4:0] + 5'h01]) begin
                                        pin_q <= '{oe: 1'b1, o: 1'b0};
                                        drove_low_q <= 1'b1;
                                    end else begin
                                        drove_low_q <= 1'b0;
                                    end
                                    last_vec_q[frame_q[4:0] + 5'h01] <=
                                        frame_vec[frame_q[4:0] + 5'h01];
                                end else begin
                                    drove_low_q <= 1'b0;
                                end
                            end
                            PH_SAMPLE: begin
                                // the frame's owner restores the line high
                                phase_q <= PH_RECOVER;
                                if (drove_low_q) begin
                                    pin_q <= '{oe: 1'b1, o: 1'b1};
                                end
                            end
                            default: begin
                                // recovery done: release for turn-around
                                phase_q <= PH_TURN;
                                drove_low_q <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (!line_smp_q) begin
                        if (low_cnt_q != LOW_CNT_MAX) begin
                            low_cnt_q <= low_cnt_q + 4'h1;
                        end
                    end else begin
                        // two clocks choose quiet, anything else falls back safe
                        quiet_q <= (low_cnt_q == STOP_QUIET_CLKS);
                        state_q <= ST_IDLE;
                        low_cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // registered outputs; cycle_active is decoded from state_q
    assign shared_irq_line_o = pin_q.o;
    assign shared_irq_line_oe = pin_q.oe;
    assign quiet_mode = quiet_q;
    assign cycle_active = (state_q != ST_IDLE);

endmodule // sirq_periph

// >>> verilog/sirq_sync.sv
// sirq_sync: plain two-flop synchroniser for a group of asynchronous levels.
// assumes each bit is an independent level; no word coherence is promised.
`timescale 1ns/1ps
module sirq_sync #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import sirq_pkg::*;

    logic [WIDTH-1:0] meta_q; // first stage, read only by the second stage

    // two stages; the first is never looked at by any other logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sirq_sync
